// File: shared/usnak_pkg.sv
// Constants and types for the setup flag and handshake control block.
// Assumes one 25 MHz clock shared by the block and its packet decoder.

package usnak_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 25_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
    // Least time the bus supply must stand before it is reported valid
    localparam int VBUS_SETTLE_NS = 1000;
    localparam int VBUS_SETTLE_CYC =
        (VBUS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = $clog2(VBUS_SETTLE_CYC + 1);

    // ------------------------------------------------------------------
    // Power control word
    // ------------------------------------------------------------------
    localparam int PWR_CTRL_W = 8;
    localparam logic [PWR_CTRL_W-1:0] PWR_CTRL_OFF = 8'h00;

    // ------------------------------------------------------------------
    // Control endpoint
    // ------------------------------------------------------------------
    localparam int EP0_MAX_PACKET = 8;

    typedef enum logic [1:0]
    {
        USNAK_IDLE = 2'b00,
        USNAK_NAK = 2'b01,
        USNAK_DATA = 2'b11,
        USNAK_DONE = 2'b10
    } usnak_tx_state_t;

    // Token events from the packet decoder, one-cycle pulses except busy
    typedef struct packed {
        logic setup_seen;
        logic in_token_done;
        logic in_token_busy;
    } usnak_token_t;

    // Requests to the transmitter, one-cycle pulses
    typedef struct packed {
        logic nak_send;
        logic data_send;
        logic data_last;
    } usnak_tx_t;

endpackage : usnak_pkg

// File: verilog/usnak_setup_ctrl.sv
// Supply detect, power recovery, setup flag and IN handshake control.
// Assumes a packet decoder and transmitter on the same clock; the bus
// supply pin arrives asynchronously.
//
// Function
// [R1] Status bit shows valid bus supply
// [R2] All-zero power word disables regulators, clears detect
// [R3] SETUP sets flag and raises interrupt
// [R4] IN tokens NAKed while flag set
// [R5] Firmware clears flag after loading data
// [R6] Module enable low resets flag and handshake logic; supply detect resets only on reset
// [R7] Flag clear mid-token never runs transmitter away

`timescale 1ns/1ps

module usnak_setup_ctrl
    import usnak_pkg::*;
#(
    parameter int MAX_PACKET = EP0_MAX_PACKET
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Software control
    input wire logic module_enable,
    input wire logic [PWR_CTRL_W-1:0] usb_power_control,
    input wire logic setup_flag_clear,
    input wire logic in_data_ready,
    input wire logic [$clog2(MAX_PACKET+1)-1:0] in_data_count,
    // Bus supply pin
    input wire logic vbus_pin,
    // Packet decoder and transmitter
    input wire usnak_token_t token,
    input wire logic tx_ready,
    // Status and requests
    output logic vbus_valid_status,
    output logic regulator_enable,
    output logic setup_received_flag,
    output logic usb_irq,
    output usnak_tx_t tx,
    output logic tx_active
);

    localparam int CNT_W = $clog2(MAX_PACKET + 1);

    if (MAX_PACKET < 1 || MAX_PACKET > 64)
    begin : g_bad_param
        $error("MAX_PACKET must lie in 1..64");
    end

    // ------------------------------------------------------------------
    // Supply detection
    // ------------------------------------------------------------------
    logic vbus_meta;
    logic vbus_sync;
    logic power_off;
    logic vbus_valid;
    logic next_vbus_valid;
    logic [SETTLE_W-1:0] settle_cnt;
    logic [SETTLE_W-1:0] next_settle_cnt;
    logic next_vbus_valid_status;
    logic next_regulator_enable;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            vbus_meta <= 1'b0;
            vbus_sync <= 1'b0;
        end
        else
        begin
            vbus_meta <= vbus_pin;
            vbus_sync <= vbus_meta;
        end
    end

    assign power_off = (usb_power_control == PWR_CTRL_OFF);

    always_comb
    begin
        next_settle_cnt = settle_cnt;
        next_vbus_valid = vbus_valid;
        if (power_off || !vbus_sync)  // R2
        begin
            next_settle_cnt = '0;
            next_vbus_valid = 1'b0;
        end
        else if (settle_cnt == SETTLE_W'(VBUS_SETTLE_CYC - 1))  // R1
        begin
            next_vbus_valid = 1'b1;
        end
        else
        begin
            next_settle_cnt = settle_cnt + 1'b1;
        end
        next_vbus_valid_status = next_vbus_valid;  // R1
        next_regulator_enable = next_vbus_valid && !power_off;  // R2
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            settle_cnt <= '0;
            vbus_valid <= 1'b0;
            vbus_valid_status <= 1'b0;
            regulator_enable <= 1'b0;
        end
        else
        begin
            settle_cnt <= next_settle_cnt;
            vbus_valid <= next_vbus_valid;
            vbus_valid_status <= next_vbus_valid_status;
            regulator_enable <= next_regulator_enable;
        end
    end

    // ------------------------------------------------------------------
    // Setup flag and handshake state
    // ------------------------------------------------------------------
    logic mod_reset;
    usnak_tx_state_t state;
    usnak_tx_state_t next_state;
    logic next_flag;
    logic [CNT_W-1:0] remaining;
    logic [CNT_W-1:0] next_remaining;
    usnak_tx_t next_tx;

    assign mod_reset = reset || !module_enable;  // R6

    always_comb
    begin
        // Hardware set beats a firmware clear in the same cycle
        next_flag = setup_received_flag;
        if (token.setup_seen)
        begin
            next_flag = 1'b1;  // R3
        end
        else if (setup_flag_clear)
        begin
            next_flag = 1'b0;  // R5
        end

        next_state = state;
        next_remaining = remaining;
        next_tx = '0;
        unique case (state)
            USNAK_IDLE:
            begin
                // Decision taken once, at token end, from the registered
                // flag; a clear in the cycle the token ends only affects later ones
                if (token.in_token_done)  // R7
                begin
                    if (setup_received_flag || !in_data_ready)  // R4
                    begin
                        next_state = USNAK_NAK;
                        next_tx.nak_send = 1'b1;
                    end
                    else
                    begin
                        next_state = USNAK_DATA;
                        next_remaining = (in_data_count > CNT_W'(MAX_PACKET))
                            ? CNT_W'(MAX_PACKET) : in_data_count;
                    end
                end
            end
            USNAK_NAK:
            begin
                next_state = USNAK_DONE;
            end
            USNAK_DATA:
            begin
                // Byte count is bounded, so the packet ends after at most MAX_PACKET bytes taken with tx_ready
                if (remaining == '0)  // R7
                begin
                    next_tx.data_last = 1'b1;
                    next_state = USNAK_DONE;
                end
                else if (tx_ready)
                begin
                    next_tx.data_send = 1'b1;
                    next_remaining = remaining - 1'b1;
                end
            end
            USNAK_DONE:
            begin
                next_state = USNAK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (mod_reset)  // R6
        begin
            state <= USNAK_IDLE;
            remaining <= '0;
            setup_received_flag <= 1'b0;
            usb_irq <= 1'b0;
            tx <= '0;
            tx_active <= 1'b0;
        end
        else
        begin
            state <= next_state;
            remaining <= next_remaining;
            setup_received_flag <= next_flag;
            usb_irq <= next_flag;  // R3
            tx <= next_tx;
            tx_active <= (next_state != USNAK_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [CNT_W:0] bytes_sent;

    always_ff @(posedge clk)
    begin
        if (mod_reset || state == USNAK_IDLE)
        begin
            bytes_sent <= '0;
        end
        else if (tx.data_send)
        begin
            bytes_sent <= bytes_sent + 1'b1;
        end
    end

    sequence flagged_in_s;
        setup_received_flag && token.in_token_done && state == USNAK_IDLE;
    endsequence

    sequence nak_only_s;
        tx.nak_send && !tx.data_send ##1 !tx.data_send ##1 !tx.data_send;
    endsequence

    vbus_status_a: assert property (  // R1
        @(posedge clk) disable iff (reset)
        !vbus_sync |-> ##2 !vbus_valid_status)
        else $error("supply status stayed set without supply");

    power_off_a: assert property (  // R2
        @(posedge clk) disable iff (reset)
        power_off |-> ##2 (!regulator_enable && !vbus_valid_status))
        else $error("power word zero did not disable regulators");

    setup_flag_a: assert property (  // R3
        @(posedge clk) disable iff (mod_reset)
        token.setup_seen |=> setup_received_flag && usb_irq)
        else $error("setup did not set flag and interrupt");

    in_nak_a: assert property (  // R4
        @(posedge clk) disable iff (mod_reset)
        flagged_in_s |=> nak_only_s)
        else $error("IN token not NAKed while flag set");

    enable_reset_a: assert property (  // R6
        @(posedge clk) disable iff (reset)
        !module_enable |=> state == USNAK_IDLE && !setup_received_flag
            && !tx_active && tx == '0)
        else $error("module enable low did not reset module");

    bounded_tx_a: assert property (  // R7
        @(posedge clk) disable iff (mod_reset)
        bytes_sent <= (CNT_W+1)'(MAX_PACKET))
        else $error("transmitter exceeded packet length");

endmodule : usnak_setup_ctrl

// File: test/usnak_host_model.sv
// Behavioural packet decoder and transmitter facing the handshake block.
// Assumes commands from the bench arrive just after a rising edge.

`timescale 1ns/1ps

module usnak_host_model
    import usnak_pkg::*;
(
    // Clock
    input wire logic clk,
    // Commands from the bench
    input wire logic send_setup,
    input wire logic send_in,
    input wire logic slow,
    // Decoder and transmitter side
    output usnak_token_t token,
    output logic tx_ready
);
    // ------------------------------------------------------------
    // Token timing: an IN token is busy one cycle, then done
    // ------------------------------------------------------------
    initial token = '0;
    initial tx_ready = 1'b0;
    always @(posedge clk)
    begin
        token.setup_seen <= send_setup;
        token.in_token_busy <= send_in;
        token.in_token_done <= token.in_token_busy;
        // A slow transmitter accepts every other cycle
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
endmodule : usnak_host_model

// File: test/testbench.sv
// Self-checking bench for the setup flag and handshake control block.
// Assumes the host model file is compiled before this one.

`timescale 1ns/1ps

module testbench
    import usnak_pkg::*;
;
    logic clk, reset, module_enable, setup_flag_clear, in_data_ready;
    logic vbus_pin, send_setup, send_in, slow, tx_ready, tx_active;
    logic vbus_valid_status, regulator_enable, setup_received_flag, usb_irq;
    logic [7:0] usb_power_control;
    logic [3:0] in_data_count;
    usnak_token_t token;
    usnak_tx_t tx;
    logic [7:0] expq[$];
    int errors, compares, n, i, nb;
    integer seed;

    usnak_setup_ctrl #(.MAX_PACKET(EP0_MAX_PACKET)) dut (.clk(clk),
        .reset(reset), .module_enable(module_enable),
        .usb_power_control(usb_power_control),
        .setup_flag_clear(setup_flag_clear), .in_data_ready(in_data_ready),
        .in_data_count(in_data_count), .vbus_pin(vbus_pin), .token(token),
        .tx_ready(tx_ready), .vbus_valid_status(vbus_valid_status),
        .regulator_enable(regulator_enable),
        .setup_received_flag(setup_received_flag), .usb_irq(usb_irq),
        .tx(tx), .tx_active(tx_active));
    usnak_host_model host (.clk(clk), .send_setup(send_setup),
        .send_in(send_in), .slow(slow), .token(token), .tx_ready(tx_ready));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task test_done;
        if (errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task tick;
        @(posedge clk);
        #2;
    endtask : tick

    task chk(input string name, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    task wait_vbus;
        n = 0;
        while (vbus_valid_status !== 1'b1 && n < 100)
        begin
            tick;
            n++;
        end
        if (n == 100)
        begin
            errors++;
            test_done;
        end
    endtask : wait_vbus

    // IN token; clr pulses the flag clear in the cycle the token ends
    task in_tok(input logic [7:0] e, input logic clr);
        expq.push_back(e);
        send_in = 1'b1;
        tick;
        send_in = 1'b0;
        tick;
        setup_flag_clear = clr;
        tick;
        setup_flag_clear = 1'b0;
        n = 0;
        while (tx_active !== 1'b0 && n < 100)
        begin
            tick;
            n++;
        end
        if (n == 100)
        begin
            errors++;
            test_done;
        end
        tick;
    endtask : in_tok

    task take(input logic [7:0] g);
        chk("tx result", expq.size() > 0 ? expq.pop_front() : 8'hEE, g);
    endtask : take

    // ------------------------------------------------------------
    // Clock, watchdog, result monitor
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        #(40 * 20000);
        errors++;
        test_done;
    end

    always @(posedge clk)
    begin
        #1;
        if (module_enable !== 1'b1)
            nb = 0;
        if (tx.data_send === 1'b1)
            nb++;
        if (tx.nak_send === 1'b1)
            take(8'hFF);
        if (tx.data_last === 1'b1)
        begin
            take(8'(nb));
            nb = 0;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'hc18b;
        {reset, module_enable} = 2'b11;
        {setup_flag_clear, in_data_ready, vbus_pin} = 3'b000;
        {send_setup, send_in, slow} = 3'b000;
        usb_power_control = PWR_CTRL_OFF;
        in_data_count = 4'h0;
        repeat (12) @(posedge clk);
        #2;
        reset = 1'b0;
        usb_power_control = 8'($random(seed)) | 8'h01;
        vbus_pin = 1'b1;
        wait_vbus;
        chk("vbus delay", 8'(VBUS_SETTLE_CYC + 2), 8'(n));
        chk("regulator", 8'h01, {7'h00, regulator_enable});
        usb_power_control = PWR_CTRL_OFF;
        tick;
        tick;
        chk("power off", 8'h00,
            {6'h00, vbus_valid_status, regulator_enable});
        usb_power_control = 8'h80;
        wait_vbus;
        chk("power back", 8'h01, {7'h00, vbus_valid_status});
        // Supply loss must clear the status three edges later
        vbus_pin = 1'b0;
        repeat (3) tick;
        chk("vbus drop", 8'h00,
            {6'h00, vbus_valid_status, regulator_enable});
        vbus_pin = 1'b1;
        wait_vbus;
        chk("vbus return", 8'h01, {7'h00, vbus_valid_status});
        send_setup = 1'b1;
        tick;
        send_setup = 1'b0;
        tick;
        chk("flag irq", 8'h03, {6'h00, setup_received_flag, usb_irq});
        in_data_ready = 1'b1;
        in_data_count = 4'h3;
        in_tok(8'hFF, 1'b0);
        in_tok(8'hFF, 1'b0);
        in_tok(8'hFF, 1'b1);
        chk("flag clear", 8'h00, {6'h00, setup_received_flag, usb_irq});
        for (i = 0; i < 6; i++)
        begin
            in_data_count = 4'($random(seed));
            slow = i[0];
            in_tok(in_data_count > EP0_MAX_PACKET ? 8'(EP0_MAX_PACKET) :
                8'(in_data_count), 1'b0);
        end
        in_data_ready = 1'b0;
        in_tok(8'hFF, 1'b0);
        in_data_ready = 1'b1;
        in_data_count = 4'h8;
        send_in = 1'b1;
        tick;
        send_in = 1'b0;
        send_setup = 1'b1;
        tick;
        send_setup = 1'b0;
        repeat (3) tick;
        module_enable = 1'b0;
        tick;
        tick;
        chk("disable", 8'h00,
            {5'h00, tx_active, setup_received_flag, usb_irq});
        module_enable = 1'b1;
        tick;
        in_tok(8'h08, 1'b0);
        chk("pending", 8'h00, 8'(expq.size()));
        test_done;
    end
endmodule : testbench
